// ### inc/sps_map.svh
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// Register byte offsets on the Avalon-MM slave.
`define SPS_REG_CTRL 4'h0
`define SPS_REG_STEP 4'h4
`define SPS_REG_STAT 4'h8
`define SPS_REG_RATE 4'hC

// Control register fields.
`define SPS_CTRL_EN_BIT 0
`define SPS_CTRL_DIR_BIT 1
`define SPS_CTRL_RUN_BIT 2
`define SPS_CTRL_MODE_LO 4
`define SPS_CTRL_MODE_HI 6

// Reset values.
`define SPS_CTRL_RESET 32'h0000_0000
`define SPS_RATE_RESET 32'h0000_C350

// Pattern table lengths.
`define SPS_LEN_FULL 5'h04
`define SPS_LEN_HALF 5'h08
`define SPS_LEN_QUARTER 5'h10

// Code driven on every current-code bit in the full-current patterns.
`define SPS_CODE_FULL 4'hF

// Bridge restart delay after an overcurrent trip, in ns, and its cycle count.
`define SPS_CLK_NS 20
`define SPS_RESTART_NS 3000
`define SPS_RESTART_CYC ((`SPS_RESTART_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)

`endif

// ### inc/sps_pkg.sv
package sps_pkg;

	// Step pattern selection.
	typedef enum logic [2:0] {
		SPS_MODE_WAVE = 3'h0,
		SPS_MODE_TWO_ON = 3'h1,
		SPS_MODE_HALF = 3'h2,
		SPS_MODE_HALF_COMP = 3'h3,
		SPS_MODE_QUARTER = 3'h4
	} sps_mode_t;

	// Bus slave state.
	typedef enum logic [1:0] {
		SPS_BUS_IDLE = 2'h0,
		SPS_BUS_DONE = 2'h1
	} sps_bus_t;

	// One table entry for both windings.
	typedef struct packed {
		logic [3:0] code_a;
		logic dir_a;
		logic [3:0] code_b;
		logic dir_b;
	} sps_drive_t;

endpackage : sps_pkg

// ### logic/sps_pattern_lut.sv
`include "sps_map.svh"

// Maps a pattern mode and table index to the winding codes and directions.
module sps_pattern_lut
	import sps_pkg::*;
(
	input wire logic [2:0] mode_i,
	input wire logic [3:0] index_i,
	output sps_drive_t drive_o
);

	// Quarter-step magnitude of the cosine, 22.5 degree spacing, over one quadrant.
	function automatic logic [3:0] sps_mag(input logic [1:0] q);
		case (q)
			2'h0: sps_mag = 4'hF;
			2'h1: sps_mag = 4'hE;
			2'h2: sps_mag = 4'hB;
			default: sps_mag = 4'h6;
		endcase
	endfunction : sps_mag

	logic [3:0] qidx;
	logic [1:0] sub;
	logic [3:0] cos_code;
	logic [3:0] sin_code;

	// All patterns are mapped onto the sixteen-entry quarter-step circle.
	always_comb begin
		case (mode_i)
			SPS_MODE_TWO_ON: qidx = {index_i[1:0], 2'h2};
			SPS_MODE_HALF, SPS_MODE_HALF_COMP: qidx = {index_i[2:0], 1'b0};
			SPS_MODE_QUARTER: qidx = index_i;
			default: qidx = {index_i[1:0], 2'h0}; // Unused mode codes run as wave drive.
		endcase
		sub = qidx[1:0];
		// Cosine magnitude folds every quadrant; sine is its mirror.
		cos_code = qidx[2] ? sps_mag(2'h0 - sub) : sps_mag(sub); // [RQ13]
		sin_code = qidx[2] ? sps_mag(sub) : sps_mag(2'h0 - sub); // [RQ13]
		if (sub == 2'h0) begin
			cos_code = qidx[2] ? 4'h0 : 4'hF;
			sin_code = qidx[2] ? 4'hF : 4'h0;
		end
		drive_o.dir_a = (qidx <= 4'h4) ? (qidx != 4'h4) : (qidx >= 4'hC); // [RQ15]
		drive_o.dir_b = (qidx <= 4'h8) ? (qidx != 4'h8) : 1'b0; // [RQ15]
		// Full-current patterns drive every code bit high on the lit windings.
		case (mode_i)
			SPS_MODE_TWO_ON: begin
				drive_o.code_a = `SPS_CODE_FULL; // [RQ8] [RQ9]
				drive_o.code_b = `SPS_CODE_FULL; // [RQ9]
			end
			SPS_MODE_HALF: begin
				drive_o.code_a = (cos_code == 4'h0) ? 4'h0 : `SPS_CODE_FULL; // [RQ11]
				drive_o.code_b = (sin_code == 4'h0) ? 4'h0 : `SPS_CODE_FULL; // [RQ11]
			end
			SPS_MODE_HALF_COMP, SPS_MODE_QUARTER: begin
				drive_o.code_a = cos_code; // [RQ13] [RQ14] [RQ17]
				drive_o.code_b = sin_code; // [RQ13] [RQ14] [RQ17]
			end
			default: begin
				drive_o.code_a = qidx[2] ? 4'h0 : `SPS_CODE_FULL; // [RQ6]
				drive_o.code_b = qidx[2] ? `SPS_CODE_FULL : 4'h0; // [RQ6]
			end
		endcase
	end

endmodule : sps_pattern_lut

// ### logic/sps_step_timer.sv
`include "sps_map.svh"

// Free-running divider giving one step-enable pulse per programmed period.
module sps_step_timer
	import sps_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic [31:0] period_i,
	output logic tick_o
);

	logic [31:0] count;

	// A period of zero is treated as one so the pulse never stalls.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			count <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (count + 32'h0000_0001 >= period_i) begin
			count <= 32'h0000_0000;
			tick_o <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick_o <= 1'b0;
		end
	end

endmodule : sps_step_timer

// ### logic/sps_sequencer.sv
// Notes on behaviour
// [RQ1] Bridge cuts source switches above current limit.
// [RQ2] Bridge restarts about 3 us after fault.
// [RQ3] Persistent overcurrent cycles thermal shutdown, no latch.
// [RQ4] Bridge off while hot, restarts after hysteresis.
// [RQ5] Bridge off under low supply, auto restart.
// [RQ6] Wave drive: A, B, A reversed, B reversed.
// [RQ7] Reverse rotation walks sequence backwards.
// [RQ8] Two-phase-on cycles AB, A*B, A*B*, AB*.
// [RQ9] Two-phase-on holds all code bits one.
// [RQ10] Brake inputs held zero while stepping.
// [RQ11] Half step walks eight one/two winding states.
// [RQ12] Compensated half step advances 45 degrees.
// [RQ13] Codes are rounded cosine and sine magnitudes.
// [RQ14] Half table 15/0, 11/11, 0/15 repeating.
// [RQ15] Direction bits follow cosine and sine sign.
// [RQ16] Any level change counts one half step.
// [RQ17] Quarter step advances 22.5 degrees per microstep.
// [RQ18] Bridge threshold is reference times code over 16.
// [RQ19] One entry per step, direction chosen, wrapping.
`include "sps_map.svh"

module sps_sequencer
	import sps_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [3:0] phase_a_current_code_o,
	output logic phase_a_dir_o,
	output logic phase_a_brake_o,
	output logic [3:0] phase_b_current_code_o,
	output logic phase_b_dir_o,
	output logic phase_b_brake_o
);

	logic [31:0] ctrl;
	logic [31:0] rate;
	logic [3:0] index;
	logic [31:0] step_count;
	logic sw_step;
	logic tick;
	logic step_now;
	logic [3:0] next_index;
	logic [4:0] len;
	logic [2:0] mode;
	sps_drive_t drive;
	sps_bus_t bus_state;
	logic [31:0] next_readdata;
	logic [31:0] wmask;

	assign mode = ctrl[`SPS_CTRL_MODE_HI:`SPS_CTRL_MODE_LO];

	// Byte-enable mask so partial writes only touch the addressed lanes.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_mask
			assign wmask[8*g+7:8*g] = {8{avs_byteenable_i[g]}};
		end
	endgenerate

	// Every access answers one cycle after it is seen, so waitrequest is high
	// on the first cycle and low on the second; this keeps readdata registered.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_state <= SPS_BUS_IDLE;
		end else begin
			case (bus_state)
				SPS_BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_state <= SPS_BUS_DONE;
					end
				end
				SPS_BUS_DONE: begin
					bus_state <= SPS_BUS_IDLE;
				end
				default: begin
					bus_state <= SPS_BUS_IDLE;
				end
			endcase
		end
	end

	// Waitrequest stays high except in the answer cycle.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((bus_state == SPS_BUS_IDLE) && (avs_read_i || avs_write_i));
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (avs_address_i)
			`SPS_REG_CTRL: next_readdata = ctrl;
			`SPS_REG_STEP: next_readdata = step_count;
			`SPS_REG_STAT: next_readdata = {18'h0_0000, drive.dir_b, drive.code_b,
				drive.dir_a, drive.code_a, index};
			`SPS_REG_RATE: next_readdata = rate;
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// Read data is loaded in the same edge that drops waitrequest.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if ((bus_state == SPS_BUS_IDLE) && avs_read_i) begin
			avs_readdata_o <= next_readdata;
		end
	end

	// Control writes land at the accepting edge; an invalid mode falls back to wave.
	// Bits without a meaning are dropped so software reads back only live fields.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl <= `SPS_CTRL_RESET;
		end else if ((bus_state == SPS_BUS_DONE) && avs_write_i
			&& (avs_address_i == `SPS_REG_CTRL)) begin
			ctrl <= (ctrl & ~wmask) | (avs_writedata_i & wmask & 32'h0000_0077);
		end
	end

	// The step period is a plain cycle count; the timer treats zero as one.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rate <= `SPS_RATE_RESET;
		end else if ((bus_state == SPS_BUS_DONE) && avs_write_i
			&& (avs_address_i == `SPS_REG_RATE)) begin
			rate <= (rate & ~wmask) | (avs_writedata_i & wmask);
		end
	end

	// Writing bit 0 of the step register requests one single step.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sw_step <= 1'b0;
		end else begin
			sw_step <= (bus_state == SPS_BUS_DONE) && avs_write_i
				&& (avs_address_i == `SPS_REG_STEP) && avs_byteenable_i[0]
				&& avs_writedata_i[0];
		end
	end

	// Automatic stepping rate; a period counts clock cycles.
	sps_step_timer u_timer (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.run_i(ctrl[`SPS_CTRL_RUN_BIT] && ctrl[`SPS_CTRL_EN_BIT]),
		.period_i(rate),
		.tick_o(tick)
	);

	assign step_now = ctrl[`SPS_CTRL_EN_BIT] && (tick || sw_step);

	// Table length by pattern.
	always_comb begin
		case (mode)
			SPS_MODE_WAVE: len = `SPS_LEN_FULL;
			SPS_MODE_TWO_ON: len = `SPS_LEN_FULL;
			SPS_MODE_HALF: len = `SPS_LEN_HALF;
			SPS_MODE_HALF_COMP: len = `SPS_LEN_HALF; // [RQ12]
			SPS_MODE_QUARTER: len = `SPS_LEN_QUARTER; // [RQ17]
			default: len = `SPS_LEN_FULL;
		endcase
	end

	// One entry per step, forward or backward, wrapping at the table length.
	always_comb begin
		if (ctrl[`SPS_CTRL_DIR_BIT]) begin
			next_index = (index == 4'h0) ? 4'(len - 5'h01) : index - 4'h1; // [RQ7] [RQ19]
		end else begin
			next_index = ({1'b0, index} + 5'h01 >= len) ? 4'h0 : index + 4'h1; // [RQ19]
		end
	end

	// Step position and a count of taken steps, visible to software.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			index <= 4'h0;
			step_count <= 32'h0000_0000;
		end else if ((bus_state == SPS_BUS_DONE) && avs_write_i
			&& (avs_address_i == `SPS_REG_CTRL)) begin
			index <= 4'h0; // A pattern change restarts at angle zero.
		end else if (step_now) begin
			index <= next_index;
			step_count <= step_count + 32'h0000_0001; // [RQ16]
		end
	end

	sps_pattern_lut u_lut (
		.mode_i(mode),
		.index_i(index),
		.drive_o(drive)
	);

	// Bridge pins are registered; disabled means zero current code.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_a_current_code_o <= 4'h0;
			phase_b_current_code_o <= 4'h0;
			phase_a_dir_o <= 1'b0;
			phase_b_dir_o <= 1'b0;
			phase_a_brake_o <= 1'b0;
			phase_b_brake_o <= 1'b0;
		end else begin
			phase_a_current_code_o <= ctrl[`SPS_CTRL_EN_BIT] ? drive.code_a : 4'h0; // [RQ18]
			phase_b_current_code_o <= ctrl[`SPS_CTRL_EN_BIT] ? drive.code_b : 4'h0;
			phase_a_dir_o <= drive.dir_a; // [RQ15]
			phase_b_dir_o <= drive.dir_b;
			phase_a_brake_o <= 1'b0; // [RQ10]
			phase_b_brake_o <= 1'b0; // [RQ10]
		end
	end

	// Brakes never rise.
	chk_brake_low: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ10]
		!phase_a_brake_o && !phase_b_brake_o) else $error("brake raised");

	// Two-phase-on drives full code on both windings.
	chk_two_on_full: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ9]
		(ctrl[`SPS_CTRL_EN_BIT] && mode == SPS_MODE_TWO_ON) |=>
		(phase_a_current_code_o == 4'hF && phase_b_current_code_o == 4'hF))
		else $error("two-phase code not full");

	// Two-phase-on starts with both windings in the positive sense.
	chk_two_on_start: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ8]
		(mode == SPS_MODE_TWO_ON && index == 4'h0) |-> (drive.dir_a && drive.dir_b))
		else $error("two-phase start wrong");

	// A forward step from the last entry wraps to zero.
	chk_step_advance: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ19]
		(step_now && !avs_write_i && !ctrl[`SPS_CTRL_DIR_BIT] && index == 4'(len - 5'h01))
		|=> index == 4'h0) else $error("forward wrap wrong");

	// A forward step inside the table adds exactly one.
	chk_fwd_step: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ19]
		(step_now && !avs_write_i && !ctrl[`SPS_CTRL_DIR_BIT] && ({1'b0, index} + 5'h01 < len))
		|=> index == $past(index) + 4'h1) else $error("forward step wrong");

	// Reverse from zero goes to the last entry.
	chk_reverse_wrap: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ7]
		(step_now && !avs_write_i && ctrl[`SPS_CTRL_DIR_BIT] && index == 4'h0)
		|=> index == 4'($past(len) - 5'h01)) else $error("reverse wrap wrong");

	// A reverse step away from zero takes exactly one off.
	chk_rev_step: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ7]
		(step_now && !avs_write_i && ctrl[`SPS_CTRL_DIR_BIT] && index != 4'h0)
		|=> index == $past(index) - 4'h1) else $error("reverse step wrong");

	// No step request, no motion.
	chk_index_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ19]
		(!step_now && !avs_write_i) |=> $stable(index)) else $error("index moved");

	// The index never points past the end of the pattern in use.
	chk_index_range: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ19]
		{1'b0, index} < len) else $error("index out of table");

	// A control write always restarts the pattern at angle zero.
	chk_ctrl_restart: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		((bus_state == SPS_BUS_DONE) && avs_write_i && (avs_address_i == `SPS_REG_CTRL))
		|=> index == 4'h0) else $error("pattern not restarted");

	// Every taken step is counted once.
	chk_step_count: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ16]
		(step_now && !avs_write_i) |=> step_count == $past(step_count) + 32'h0000_0001)
		else $error("step count wrong");

	// Compensated half step at 45 degrees gives 11/11.
	chk_half_comp: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ14]
		(mode == SPS_MODE_HALF_COMP && index == 4'h1) |->
		(drive.code_a == 4'hB && drive.code_b == 4'hB && drive.dir_a && drive.dir_b))
		else $error("half table wrong");

	// Compensated half step only uses the three table levels.
	chk_comp_levels: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ14]
		mode == SPS_MODE_HALF_COMP |->
		((drive.code_a == 4'h0 || drive.code_a == 4'hB || drive.code_a == 4'hF)
		&& (drive.code_b == 4'h0 || drive.code_b == 4'hB || drive.code_b == 4'hF)))
		else $error("half level wrong");

	// Plain half step lights windings fully or not at all, never both dark.
	chk_half_levels: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ11]
		mode == SPS_MODE_HALF |->
		((drive.code_a == 4'h0 || drive.code_a == 4'hF)
		&& (drive.code_b == 4'h0 || drive.code_b == 4'hF)
		&& (drive.code_a != 4'h0 || drive.code_b != 4'h0)))
		else $error("half step level wrong");

	// Quarter step at 22.5 degrees gives 14/6.
	chk_quarter_tab: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ17]
		(mode == SPS_MODE_QUARTER && index == 4'h1) |->
		(drive.code_a == 4'hE && drive.code_b == 4'h6)) else $error("quarter table wrong");

	// Wave drive lights exactly one winding.
	chk_wave_one: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ6]
		mode == SPS_MODE_WAVE |-> ((drive.code_a == 4'h0) != (drive.code_b == 4'h0)))
		else $error("wave not single winding");

	// The second wave entry hands over to winding B, positive.
	chk_wave_order: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ6]
		(mode == SPS_MODE_WAVE && index == 4'h1) |->
		(drive.code_a == 4'h0 && drive.code_b == 4'hF && drive.dir_b))
		else $error("wave order wrong");

	// Direction A negative from 90 to 270 degrees.
	chk_dir_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ15]
		(mode == SPS_MODE_QUARTER && index >= 4'h4 && index <= 4'hB) |-> !drive.dir_a)
		else $error("direction A wrong");

	// Direction B positive for the first half turn only.
	chk_dir_b: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ15]
		mode == SPS_MODE_QUARTER |-> (drive.dir_b == (index < 4'h8)))
		else $error("direction B wrong");

	// While enabled the pins carry the table entry one cycle later.
	chk_pins_track: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RQ13]
		ctrl[`SPS_CTRL_EN_BIT] |=> (phase_a_current_code_o == $past(drive.code_a)
		&& phase_b_current_code_o == $past(drive.code_b)))
		else $error("pins lag table");

	// A disabled controller asks the bridge for no current at all.
	chk_disabled_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!ctrl[`SPS_CTRL_EN_BIT] |=>
		(phase_a_current_code_o == 4'h0 && phase_b_current_code_o == 4'h0))
		else $error("current while disabled");

	// Waitrequest falls one cycle after a read request.
	chk_bus_answer: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(avs_read_i && bus_state == SPS_BUS_IDLE) |=> !avs_waitrequest_o)
		else $error("bus answer late");

	// Writes are answered on the same schedule as reads.
	chk_write_answer: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(avs_write_i && bus_state == SPS_BUS_IDLE) |=> !avs_waitrequest_o)
		else $error("write answer late");

	// The answer stands one cycle only, so a held request is not taken twice.
	chk_wait_short: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer held too long");

endmodule : sps_sequencer

// ### tb/sps_bridge_model.sv
// Behavioural model of one dual full-bridge driver that the sequencer feeds.
module sps_bridge_model #(
	parameter int RESTART_CYC = 150,
	parameter int REF_LEVEL = 240
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] code_a_i,
	input wire logic brake_a_i,
	input wire logic [3:0] code_b_i,
	input wire logic brake_b_i,
	input wire logic over_current_i,
	input wire logic hot_i,
	input wire logic low_supply_i,
	output logic bridge_on_o,
	output logic [7:0] thresh_a_o,
	output logic [7:0] thresh_b_o,
	output logic brake_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic tripped;
	int wait_cnt;

	// A trip drops both source switches; restart is automatic, never latched.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tripped <= 1'b0;
			wait_cnt <= 0;
		end else if (over_current_i) begin
			tripped <= 1'b1;
			wait_cnt <= 0;
		end else if (tripped) begin
			if (wait_cnt == RESTART_CYC - 1) begin
				tripped <= 1'b0;
			end
			wait_cnt <= wait_cnt + 1;
		end
	end

	// Heat and low supply disable the bridge only while they last.
	assign bridge_on_o = !tripped && !hot_i && !low_supply_i;

	// Chopping threshold scales with the code: reference level times code over 16.
	assign thresh_a_o = 8'((REF_LEVEL * code_a_i) / 16);
	assign thresh_b_o = 8'((REF_LEVEL * code_b_i) / 16);

	// Sticky flag: a brake request during stepping is a controller fault.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			brake_seen_o <= 1'b0;
		end else if (brake_a_i || brake_b_i) begin
			brake_seen_o <= 1'b1;
		end
	end
endmodule : sps_bridge_model

// ### tb/stepper_phase_sequencer_bench.sv
`include "sps_map.svh"
`define SPS_CHECK(what, exp, got) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("Error %s expected %h seen %h", what, exp, got); \
	end \
end

module stepper_phase_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable, code_a, code_b;
	logic [31:0] avs_writedata, avs_readdata;
	logic dir_a, dir_b, brake_a, brake_b, brake_seen;
	int errors, check_count;

	sps_sequencer sps_sequencer_inst (.clock_i(clock), .rst_b_i(rst_b),
		.avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.phase_a_current_code_o(code_a), .phase_a_dir_o(dir_a), .phase_a_brake_o(brake_a),
		.phase_b_current_code_o(code_b), .phase_b_dir_o(dir_b), .phase_b_brake_o(brake_b));

	sps_bridge_model sps_bridge_model_inst (.clock_i(clock), .rst_b_i(rst_b),
		.code_a_i(code_a), .brake_a_i(brake_a), .code_b_i(code_b), .brake_b_i(brake_b),
		.over_current_i(1'b0), .hot_i(1'b0), .low_supply_i(1'b0), .bridge_on_o(),
		.thresh_a_o(), .thresh_b_o(), .brake_seen_o(brake_seen));

	// Free-running 50 MHz clock.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic finish_test;
		if (errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	// One Avalon cycle; held until waitrequest is sampled low, then released.
	task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data,
		input logic [3:0] lanes, output logic [31:0] rdata);
		int n;
		@(posedge clock);
		avs_address <= addr;
		avs_writedata <= data;
		avs_byteenable <= lanes;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			finish_test();
		end
	endtask : bus

	task automatic wr(input logic [3:0] addr, input logic [31:0] data);
		logic [31:0] q;
		bus(1'b1, addr, data, 4'hF, q);
		repeat (5) @(posedge clock);
	endtask : wr

	task automatic rd(input logic [3:0] addr, output logic [31:0] q);
		bus(1'b0, addr, 32'h0000_0000, 4'hF, q);
	endtask : rd

	// Expected {code_a, dir_a, code_b, dir_b}; q is the angle in 22.5 degree units.
	function automatic logic [9:0] expv(input int m, input int i);
		logic [3:0] cq[8];
		logic [3:0] ca, cb;
		int q;
		cq = '{4'hF, 4'hE, 4'hB, 4'h6, 4'h0, 4'h6, 4'hB, 4'hE};
		q = (m == 4) ? i : ((m == 2 || m == 3) ? i * 2 : i * 4);
		ca = cq[q % 8];
		cb = cq[(q + 4) % 8];
		if (m == 1) begin
			ca = 4'hF;
			cb = 4'hF;
		end else if (m == 2) begin
			ca = (q % 8 != 4) ? 4'hF : 4'h0;
			cb = (q % 8 != 0) ? 4'hF : 4'h0;
		end
		return {ca, (q < 4 || q >= 12), cb, (q < 8)};
	endfunction : expv

	initial begin
		logic [31:0] q;
		int len, idx;
		errors = 0;
		check_count = 0;
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		rd(`SPS_REG_CTRL, q);
		`SPS_CHECK("ctrl reset", `SPS_CTRL_RESET, q)
		rd(`SPS_REG_RATE, q);
		`SPS_CHECK("rate reset", `SPS_RATE_RESET, q)
		rd(4'h2, q);
		`SPS_CHECK("unmapped read", 32'h0000_0000, q)
		// Steps while disabled must leave the bridge idle.
		wr(`SPS_REG_STEP, 32'h0000_0001);
		`SPS_CHECK("pins disabled", {4'h0, 1'b1, 4'h0, 1'b1}, {code_a, dir_a, code_b, dir_b})
		bus(1'b1, `SPS_REG_CTRL, 32'h0000_0001, 4'hE, q);
		rd(`SPS_REG_CTRL, q);
		`SPS_CHECK("ctrl masked lane", 32'h0000_0000, q)
		// Every mode, both rotations, one lap plus a wrap.
		for (int m = 0; m < 6; m++) begin
			for (int r = 0; r < 2; r++) begin
				len = (m == 4) ? 16 : ((m == 2 || m == 3) ? 8 : 4);
				wr(`SPS_REG_CTRL, 32'(1 + r * 2 + m * 16));
				for (int n = 0; n <= len + 1; n++) begin
					if (n > 0) begin
						wr(`SPS_REG_STEP, 32'h0000_0001);
					end
					idx = r ? (len - n % len) % len : n % len;
					`SPS_CHECK("pins", expv(m, idx), {code_a, dir_a, code_b, dir_b})
					`SPS_CHECK("brakes", 2'b00, {brake_a, brake_b})
				end
				rd(`SPS_REG_STAT, q);
				`SPS_CHECK("stat index", 4'(idx), q[3:0])
			end
		end
		`SPS_CHECK("brake seen", 1'b0, brake_seen)
		// Timer stepping at a 64-cycle period: two steps are taken before the read.
		wr(`SPS_REG_RATE, 32'h0000_0040);
		wr(`SPS_REG_CTRL, 32'h0000_0045);
		repeat (150) @(posedge clock);
		rd(`SPS_REG_STAT, q);
		`SPS_CHECK("auto index", 4'h2, q[3:0])
		`SPS_CHECK("auto pins", expv(4, 2), {code_a, dir_a, code_b, dir_b})
		wr(`SPS_REG_CTRL, 32'h0000_0001);
		// One hundred manual steps from the laps plus the two timed ones.
		rd(`SPS_REG_STEP, q);
		`SPS_CHECK("step count", 32'h0000_0066, q)
		// A reset while enabled, with timed stepping already stopped, returns every register and pin to idle.
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		`SPS_CHECK("pins in reset", 10'h000, {code_a, dir_a, code_b, dir_b})
		rst_b <= 1'b1;
		rd(`SPS_REG_STEP, q);
		`SPS_CHECK("steps after reset", 32'h0000_0000, q)
		rd(`SPS_REG_CTRL, q);
		`SPS_CHECK("ctrl after reset", `SPS_CTRL_RESET, q)
		finish_test();
	end
endmodule : stepper_phase_sequencer_bench
